// File: design/pfac_pkg.sv
// Package of offsets, field positions, reset values and encodings for the packet filter and auto-mode block.
package pfac_pkg;

  // ------------------------------------------------------------
  // Register indices; the byte address is four times the index.
  // ------------------------------------------------------------
  localparam logic [9:0] IDX_PAYLOAD   = 10'h038;  // Payload length limit.
  localparam logic [9:0] IDX_NODE      = 10'h039;  // Own node match value.
  localparam logic [9:0] IDX_BCAST     = 10'h03a;  // Broadcast match value.
  localparam logic [9:0] IDX_AUTO      = 10'h03b;  // Automatic sequence control.
  localparam logic [9:0] IDX_CONFIG    = 10'h03c;  // Packet and mode configuration.
  localparam logic [9:0] IDX_STATUS    = 10'h03d;  // Sticky event status, cleared by read.
  localparam logic [9:0] IDX_MASK      = 10'h03e;  // Interrupt mask.
  localparam logic [9:0] IDX_MODE      = 10'h03f;  // Live mode readback.

  // ------------------------------------------------------------
  // Reset values.
  // ------------------------------------------------------------
  localparam logic [7:0] RST_PAYLOAD   = 8'h40;    // Payload length limit after reset.
  localparam logic [7:0] RST_ZERO      = 8'h00;    // All other registers after reset.

  // ------------------------------------------------------------
  // Field positions.
  // ------------------------------------------------------------
  localparam int ENTRY_LSB   = 5;                  // Entry select in bits 7 to 5.
  localparam int LEAVE_LSB   = 2;                  // Leave select in bits 4 to 2.
  localparam int TARGET_LSB  = 0;                  // Temporary target in bits 1 to 0.
  localparam int CFG_FMT     = 0;                  // Config: variable length format.
  localparam int CFG_FLT_LSB = 1;                  // Config: filter mode, bits 2 to 1.
  localparam int CFG_MODE_LSB = 3;                 // Config: software mode, bits 4 to 3.
  localparam int ST_ENTER    = 0;                  // Status: temporary mode entered.
  localparam int ST_LEAVE    = 1;                  // Status: temporary mode left.
  localparam int ST_ADDR     = 2;                  // Status: address accepted.
  localparam int ST_LEN      = 3;                  // Status: length rejected.
  localparam int ST_W        = 4;                  // Status width.

  // ------------------------------------------------------------
  // Encodings.
  // ------------------------------------------------------------
  localparam logic [2:0] SEL_NONE    = 3'h0;       // No event, automatic sequencing off.
  localparam logic [1:0] FLT_OFF     = 2'h0;       // Address filtering off.
  localparam logic [1:0] FLT_NODE    = 2'h1;       // Own node value only.
  localparam int EV_QNE  = 0;                      // Event bit: queue has data.
  localparam int EV_LVL  = 1;                      // Event bit: queue level reached.
  localparam int EV_CRC  = 2;                      // Event bit: checksum good.
  localparam int EV_RXC  = 3;                      // Event bit: received packet complete.
  localparam int EV_SYNC = 4;                      // Event bit: sync and address seen.
  localparam int EV_SENT = 5;                      // Event bit: packet sent.
  localparam int EV_TMO  = 6;                      // Event bit: timeout.
  localparam int EV_W    = 7;                      // Event vector width.

endpackage

// File: design/pfac_seq.sv
// Automatic mode sequencer: enters a temporary mode on an event edge and leaves it on another event.
`timescale 1ns/1ps
module pfac_seq (
  input  wire logic pclk,     // Bus clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  pfac_seq_if.seq   sq        // Selects, events and mode result.
);

  typedef enum logic [0:0] {PFAC_IDLE, PFAC_TEMP} pfac_state_t;

  pfac_state_t               state_q, state_d;  // Sequencer state.
  logic [pfac_pkg::EV_W-1:0] ev_q;              // Events one cycle ago.
  logic [pfac_pkg::EV_W-1:0] rise, fall;        // Edge vectors.
  logic [7:0]                entry_tab;         // Entry edges by code.
  logic [7:0]                leave_tab;         // Leave events by code.
  logic                      go_in, go_out;     // Selected entry and exit.

  assign rise = sq.events & ~ev_q;
  assign fall = ev_q & ~sq.events;
  // Entry code 001 is the queue-has-data rising edge; 111 its falling edge.
  assign entry_tab = {fall[pfac_pkg::EV_QNE], rise[pfac_pkg::EV_SENT], rise[pfac_pkg::EV_SYNC],
                      rise[pfac_pkg::EV_RXC], rise[pfac_pkg::EV_CRC], rise[pfac_pkg::EV_LVL],
                      rise[pfac_pkg::EV_QNE], 1'b0};  // RL5
  // Several exit codes pair a packet event with the timeout.
  assign leave_tab = {rise[pfac_pkg::EV_TMO], rise[pfac_pkg::EV_SENT],
                      rise[pfac_pkg::EV_SYNC] | rise[pfac_pkg::EV_TMO],
                      rise[pfac_pkg::EV_RXC] | rise[pfac_pkg::EV_TMO],
                      rise[pfac_pkg::EV_CRC] | rise[pfac_pkg::EV_TMO],
                      rise[pfac_pkg::EV_LVL] | rise[pfac_pkg::EV_TMO],
                      fall[pfac_pkg::EV_QNE], 1'b0};  // RL6
  assign go_in  = entry_tab[sq.entry_event_select];  // RL5
  // Turning sequencing off while in the temporary mode also returns at once.
  assign go_out = leave_tab[sq.leave_event_select] | (sq.entry_event_select == pfac_pkg::SEL_NONE);  // RL6

  // Next state of the sequencer.
  always_comb begin
    state_d = state_q;
    case (state_q)
      PFAC_IDLE: if (go_in) state_d = PFAC_TEMP;   // RL8
      PFAC_TEMP: if (go_out) state_d = PFAC_IDLE;  // RL8
      default:   state_d = PFAC_IDLE;
    endcase
  end

  // State, event history and the mode in force, all registered.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= PFAC_IDLE;
      ev_q        <= '0;
      sq.cur_mode <= 2'h0;
      sq.in_temp  <= 1'b0;
      sq.entered  <= 1'b0;
      sq.left     <= 1'b0;
    end else begin
      state_q     <= state_d;
      ev_q        <= sq.events;
      sq.cur_mode <= (state_d == PFAC_TEMP) ? sq.temporary_target_state : sq.sw_mode;  // RL7 RL8
      sq.in_temp  <= (state_d == PFAC_TEMP);
      sq.entered  <= (state_q == PFAC_IDLE) && (state_d == PFAC_TEMP);
      sq.left     <= (state_q == PFAC_TEMP) && (state_d == PFAC_IDLE);
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_enter; (state_q == PFAC_IDLE) && go_in; endsequence
  a_entry_takes_mode: assert property (s_enter |=> sq.in_temp && sq.entered
                                       && sq.cur_mode == $past(sq.temporary_target_state))  // RL5
    else $error("temporary mode not entered on entry edge");
  a_entry_off_idle: assert property (sq.entry_event_select == pfac_pkg::SEL_NONE |=> !sq.in_temp)  // RL5
    else $error("sequencing active while switched off");
  a_exit_returns: assert property ((state_q == PFAC_TEMP) && go_out |=> !sq.in_temp
                                   && sq.cur_mode == $past(sq.sw_mode))  // RL6
    else $error("did not return to programmed mode");
  a_exit_none_holds: assert property ((state_q == PFAC_TEMP) && !go_out |=> sq.in_temp)  // RL6
    else $error("left temporary mode without exit event");
  a_target_mode: assert property (sq.in_temp |-> sq.cur_mode == $past(sq.temporary_target_state))  // RL7
    else $error("temporary mode not the selected target");
  a_idle_sw_mode: assert property (!sq.in_temp |-> sq.cur_mode == $past(sq.sw_mode))  // RL8
    else $error("mode differs from programmed mode while idle");

endmodule // pfac_seq

// File: design/pfac_seq_if.sv
// Interface between the register block and the automatic mode sequencer.
`timescale 1ns/1ps
interface pfac_seq_if;
  logic [2:0]                   entry_event_select;      // Entry edge choice.
  logic [2:0]                   leave_event_select;      // Leave event choice.
  logic [1:0]                   temporary_target_state;  // Mode used while sequencing.
  logic [1:0]                   sw_mode;                 // Mode software programmed.
  logic [pfac_pkg::EV_W-1:0]    events;                  // Packet engine event levels.
  logic [1:0]                   cur_mode;                // Mode now in force.
  logic                         in_temp;                 // Temporary mode is active.
  logic                         entered;                 // One-cycle pulse on entry.
  logic                         left;                    // One-cycle pulse on exit.

  modport ctrl (output entry_event_select, leave_event_select, temporary_target_state, sw_mode, events,
                input cur_mode, in_temp, entered, left);
  modport seq  (input entry_event_select, leave_event_select, temporary_target_state, sw_mode, events,
                output cur_mode, in_temp, entered, left);
endinterface

// File: design/pfac_top.sv
// APB register block with length check, address filter, interrupts and the auto-mode sequencer.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps

// What this block does
// RL1: Variable format: limit caps received length only.
// RL2: Fixed format: limit is exact payload size.
// RL3: Filter compares address with own node value.
// RL4: Filter also accepts the broadcast value.
// RL5: Entry select picks starting edge; 000 off.
// RL6: Leave select picks ending event; 000 none.
// RL7: Target field picks sleep, standby or receive.
// RL8: Enter on entry edge, return on exit.
module pfac_top #(
  parameter int PADDR_W = 12                         // APB address width.
) (
  input  wire logic               pclk,              // Bus clock, 25 MHz.
  input  wire logic               presetn,           // Asynchronous reset, active low.
  input  wire logic [PADDR_W-1:0] paddr,             // APB byte address.
  input  wire logic               psel,              // APB select.
  input  wire logic               penable,           // APB access phase.
  input  wire logic               pwrite,            // APB write when high.
  input  wire logic [31:0]        pwdata,            // APB write data.
  output logic [31:0]             prdata,            // APB read data.
  output logic                    pready,            // APB ready.
  output logic                    pslverr,           // APB error on unmapped address.
  input  wire logic               queue_has_data_flag,    // Queue not empty level.
  input  wire logic               queue_level_flag,       // Queue level threshold level.
  input  wire logic               crc_good_flag,          // Checksum good level.
  input  wire logic               rx_packet_complete_flag, // Received packet ready level.
  input  wire logic               sync_address_flag,      // Sync and address seen level.
  input  wire logic               packet_sent_flag,       // Packet sent level.
  input  wire logic               timeout_flag,           // Timeout level.
  input  wire logic               rx_addr_valid,     // Pulse: received address byte valid.
  input  wire logic [7:0]         rx_addr_byte,      // Received address byte.
  input  wire logic               rx_len_valid,      // Pulse: received length byte valid.
  input  wire logic [7:0]         rx_len_byte,       // Received length byte.
  output logic [1:0]              radio_mode,        // Operating mode in force.
  output logic                    auto_active,       // Temporary mode active.
  output logic                    addr_done,         // Pulse: filter verdict ready.
  output logic                    addr_accept,       // Filter verdict, held.
  output logic                    len_done,          // Pulse: length verdict ready.
  output logic                    len_reject,        // Length verdict, held.
  output logic                    fixed_len_mode,    // Fixed length format selected.
  output logic [7:0]              payload_size_setting, // Payload length limit.
  output logic                    irq                // Level interrupt.
);

  // ------------------------------------------------------------
  // Elaboration checks.
  // ------------------------------------------------------------
  if (PADDR_W < 12) begin : g_chk_addr
    $error("PADDR_W must reach the register indices");
  end

  // ------------------------------------------------------------
  // Register state.
  // ------------------------------------------------------------
  logic [7:0]              payload_q;     // Payload length limit.
  logic [7:0]              node_q;        // Own node value.
  logic [7:0]              bcast_q;       // Broadcast value.
  logic [7:0]              auto_q;        // Automatic sequence control.
  logic [7:0]              cfg_q;         // Format, filter mode and software mode.
  logic [pfac_pkg::ST_W-1:0] status_q;    // Sticky event bits.
  logic [pfac_pkg::ST_W-1:0] status_d;    // Next sticky event bits.
  logic [pfac_pkg::ST_W-1:0] mask_q;      // Interrupt mask.
  logic [pfac_pkg::ST_W-1:0] rd_clr_q;    // Status bits returned by a pending read.

  // ------------------------------------------------------------
  // Bus decode.
  // ------------------------------------------------------------
  wire [9:0]  idx      = paddr[11:2];                                     // Word index.
  wire        aligned  = (paddr[1:0] == 2'b00);                           // Word aligned access.
  wire        mapped   = aligned && (idx >= pfac_pkg::IDX_PAYLOAD) && (idx <= pfac_pkg::IDX_MODE);
  wire        setup    = psel && !penable;                                // Setup phase.
  wire        done     = psel && penable && pready;                       // Transfer completes here.
  wire        wr_fire  = done && pwrite && !pslverr;                      // Write takes effect.
  wire        rd_fire  = done && !pwrite && !pslverr;                     // Read completes.
  wire        st_read  = rd_fire && (idx == pfac_pkg::IDX_STATUS);         // Status read completes.

  // Write strobe for one register index.
  function automatic logic wr_hit(input logic [9:0] want);
    return wr_fire && (idx == want);
  endfunction

  // Read multiplexer; unused upper bits read as zero.
  logic [7:0] rd_byte;
  always_comb begin
    case (idx)
      pfac_pkg::IDX_PAYLOAD: rd_byte = payload_q;
      pfac_pkg::IDX_NODE:    rd_byte = node_q;
      pfac_pkg::IDX_BCAST:   rd_byte = bcast_q;
      pfac_pkg::IDX_AUTO:    rd_byte = auto_q;
      pfac_pkg::IDX_CONFIG:  rd_byte = cfg_q;
      pfac_pkg::IDX_STATUS:  rd_byte = {4'h0, status_q};
      pfac_pkg::IDX_MASK:    rd_byte = {4'h0, mask_q};
      pfac_pkg::IDX_MODE:    rd_byte = {5'h00, auto_active, radio_mode};
      default:               rd_byte = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // APB answer: one wait-free access phase, data and error registered.
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      rd_clr_q <= '0;
    end else begin
      pready   <= setup;
      pslverr  <= setup && !mapped;
      prdata   <= (setup && mapped && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      // Only bits actually returned are cleared, so later events are not lost.
      rd_clr_q <= (setup && idx == pfac_pkg::IDX_STATUS) ? status_q : '0;
    end
  end

  // ------------------------------------------------------------
  // Software registers.
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      payload_q <= pfac_pkg::RST_PAYLOAD;
      node_q    <= pfac_pkg::RST_ZERO;
      bcast_q   <= pfac_pkg::RST_ZERO;
      auto_q    <= pfac_pkg::RST_ZERO;
      cfg_q     <= pfac_pkg::RST_ZERO;
      mask_q    <= '0;
    end else begin
      if (wr_hit(pfac_pkg::IDX_PAYLOAD)) payload_q <= pwdata[7:0];
      if (wr_hit(pfac_pkg::IDX_NODE))    node_q    <= pwdata[7:0];  // RL3
      if (wr_hit(pfac_pkg::IDX_BCAST))   bcast_q   <= pwdata[7:0];  // RL4
      if (wr_hit(pfac_pkg::IDX_AUTO))    auto_q    <= pwdata[7:0];
      if (wr_hit(pfac_pkg::IDX_CONFIG))  cfg_q     <= {3'h0, pwdata[4:0]};
      if (wr_hit(pfac_pkg::IDX_MASK))    mask_q    <= pwdata[pfac_pkg::ST_W-1:0];
    end
  end

  // ------------------------------------------------------------
  // Field views.
  // ------------------------------------------------------------
  wire       length_format_select = cfg_q[pfac_pkg::CFG_FMT];                      // High: variable.
  wire [1:0] filter_mode = cfg_q[pfac_pkg::CFG_FLT_LSB +: 2];                      // Filter mode.
  wire       own_hit     = (rx_addr_byte == node_q);                               // RL3
  wire       bcast_hit   = (rx_addr_byte == bcast_q);                              // RL4
  wire       addr_ok     = (filter_mode == pfac_pkg::FLT_OFF) || own_hit
                           || ((filter_mode != pfac_pkg::FLT_NODE) && bcast_hit);  // RL3 RL4
  // Transmit never consults the limit; only received lengths are checked.
  wire       len_bad     = length_format_select && (rx_len_byte > payload_q);      // RL1

  // ------------------------------------------------------------
  // Receive verdicts.
  // ------------------------------------------------------------
  // Fixed format makes every packet exactly the limit, so no verdict is needed there.
  wire       len_check   = rx_len_valid && length_format_select;                   // RL2

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_done   <= 1'b0;
      addr_accept <= 1'b0;
      len_done    <= 1'b0;
      len_reject  <= 1'b0;
    end else begin
      addr_done   <= rx_addr_valid;
      len_done    <= len_check;
      if (rx_addr_valid) addr_accept <= addr_ok;  // RL3 RL4
      if (len_check)     len_reject  <= len_bad;  // RL1
    end
  end

  // ------------------------------------------------------------
  // Static outputs.
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_len_mode       <= 1'b1;
      payload_size_setting <= pfac_pkg::RST_PAYLOAD;
    end else begin
      fixed_len_mode       <= !length_format_select;  // RL2
      payload_size_setting <= payload_q;              // RL2
    end
  end

  // ------------------------------------------------------------
  // Sequencer hookup.
  // ------------------------------------------------------------
  pfac_seq_if sq_if ();

  assign sq_if.entry_event_select     = auto_q[pfac_pkg::ENTRY_LSB +: 3];   // RL5
  assign sq_if.leave_event_select     = auto_q[pfac_pkg::LEAVE_LSB +: 3];   // RL6
  assign sq_if.temporary_target_state = auto_q[pfac_pkg::TARGET_LSB +: 2];  // RL7
  assign sq_if.sw_mode                = cfg_q[pfac_pkg::CFG_MODE_LSB +: 2];
  // Events come from packet engine logic on this clock, so no synchroniser.
  assign sq_if.events = {timeout_flag, packet_sent_flag, sync_address_flag, rx_packet_complete_flag,
                         crc_good_flag, queue_level_flag, queue_has_data_flag};

  pfac_seq u_seq (
    .pclk    (pclk),
    .presetn (presetn),
    .sq      (sq_if.seq)
  );

  assign radio_mode  = sq_if.cur_mode;
  assign auto_active = sq_if.in_temp;

  // ------------------------------------------------------------
  // Interrupts: sticky status, read clears, a new set wins.
  // ------------------------------------------------------------
  wire [pfac_pkg::ST_W-1:0] st_set = {len_done && len_reject, addr_done && addr_accept,
                                      sq_if.left, sq_if.entered};
  assign status_d = (status_q & ~(st_read ? rd_clr_q : '0)) | st_set;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= '0;
      irq      <= 1'b0;
    end else begin
      status_q <= status_d;
      irq      <= |(status_d & mask_q);
    end
  end

  // ------------------------------------------------------------
  // Checks on this block's own outputs and its status register.
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_len_in; rx_len_valid && length_format_select; endsequence
  a_len_var_limit: assert property (s_len_in |=> len_done && len_reject == ($past(rx_len_byte) > $past(payload_q)))  // RL1
    else $error("variable length verdict wrong");
  a_len_fixed_quiet: assert property (rx_len_valid && !length_format_select |=> !len_done)  // RL2
    else $error("length checked in fixed format");
  a_fixed_size_out: assert property (payload_size_setting == $past(payload_q)
                                     && fixed_len_mode == !$past(length_format_select))  // RL2
    else $error("fixed length size not presented");
  a_node_match: assert property (rx_addr_valid && own_hit |=> addr_done && addr_accept)  // RL3
    else $error("own node address refused");
  a_bcast_match: assert property (rx_addr_valid && bcast_hit && filter_mode[1] |=> addr_accept)  // RL4
    else $error("broadcast address refused");
  a_filter_reject: assert property (rx_addr_valid && filter_mode != pfac_pkg::FLT_OFF && !own_hit
                                    && !(bcast_hit && filter_mode[1]) |=> !addr_accept)  // RL3
    else $error("foreign address accepted");
  a_entry_irq: assert property (sq_if.entered |=> status_q[pfac_pkg::ST_ENTER])  // RL5
    else $error("entry event not recorded");
  a_apb_answer: assert property (setup ##1 psel && penable |-> pready)
    else $error("access phase not answered at once");

endmodule // pfac_top

// File: verification/pfac_top_tb.sv
// Self-checking testbench for the packet filter and auto-mode block.
`timescale 1ns/1ps
module pfac_top_tb;
  logic        pclk, presetn, psel, penable, pwrite, rav, rlv; // Clock, reset, bus and strobes.
  logic [11:0] paddr;                                        // Byte address.
  logic [31:0] pwdata, prdata, r;                             // Bus data.
  logic        pready, pslverr, e;                            // Bus answer.
  logic [6:0]  ev;                                            // Event levels, one per flag.
  logic [7:0]  rab, rlb, pss;                                 // Received bytes, limit copy.
  logic [1:0]  rm;                                            // Mode in force.
  logic        aa, ad, acc, ld, lr, flm, irq;                 // Verdicts and status.
  int          err_total, checks_done;                        // Counters.
  pfac_top dut_u (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .queue_has_data_flag(ev[0]), .queue_level_flag(ev[1]), .crc_good_flag(ev[2]),
    .rx_packet_complete_flag(ev[3]), .sync_address_flag(ev[4]), .packet_sent_flag(ev[5]),
    .timeout_flag(ev[6]), .rx_addr_valid(rav), .rx_addr_byte(rab), .rx_len_valid(rlv),
    .rx_len_byte(rlb), .radio_mode(rm), .auto_active(aa), .addr_done(ad), .addr_accept(acc),
    .len_done(ld), .len_reject(lr), .fixed_len_mode(flm), .payload_size_setting(pss), .irq(irq));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  task stop_test;
    if (err_total == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // APB transfer; the answer is taken at the rising edge where pready is sampled high, then released.
  task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge pclk); psel <= 1; penable <= 0; pwrite <= w; paddr <= {i, 2'b00}; pwdata <= {24'h00_0000, d};
    @(posedge pclk); penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask
  // One received byte to the filter or the length check, then the verdict.
  task rx(input logic ln, input logic [7:0] b, input logic x);
    @(posedge pclk); if (ln) begin rlv <= 1; rlb <= b; end else begin rav <= 1; rab <= b; end
    @(posedge pclk); rlv <= 0; rav <= 0;
    @(negedge pclk); chk(ln ? ld : ad, 1); chk(ln ? lr : acc, x);
  endtask
  task wmode(input logic [1:0] m);
    for (int k = 0; k < 6 && rm !== m; k++) @(negedge pclk);
    chk(rm, m);
  endtask
  task t_reset;
    apb(0, pfac_pkg::IDX_PAYLOAD, 0); chk(r, 32'h0000_0040);
    apb(0, pfac_pkg::IDX_NODE, 0); chk(r, 32'h0000_0000);
    apb(0, pfac_pkg::IDX_BCAST, 0); chk(r, 32'h0000_0000);
    apb(0, pfac_pkg::IDX_AUTO, 0); chk(r, 32'h0000_0000);
    apb(0, 10'h010, 0); chk(e, 1);
  endtask
  task t_filter;
    apb(1, pfac_pkg::IDX_CONFIG, 8'h05); apb(1, pfac_pkg::IDX_NODE, 8'h12); apb(1, pfac_pkg::IDX_BCAST, 8'ha5);
    rx(0, 8'h12, 1);
    rx(0, 8'ha5, 1);
    rx(0, 8'h13, 0);
    apb(1, pfac_pkg::IDX_CONFIG, 8'h03); rx(0, 8'ha5, 0);
  endtask
  task t_len;
    rx(1, 8'h41, 1);
    rx(1, 8'h40, 0);
    apb(1, pfac_pkg::IDX_CONFIG, 8'h00); apb(1, pfac_pkg::IDX_PAYLOAD, 8'h20);
    repeat (2) @(negedge pclk); chk(flm, 1); chk(pss, 8'h20);
    // Fixed format: a received length byte gets no verdict and leaves the held one alone.
    @(posedge pclk); rlv <= 1; rlb <= 8'h50;
    @(posedge pclk); rlv <= 0;
    @(negedge pclk); chk(ld, 0); chk(lr, 0);
  endtask
  // Enter on the chosen edge, then leave on the chosen event; status read must drop irq.
  task seq(input logic [7:0] c, input int eb, input int xb, input logic xv, input logic [1:0] t);
    apb(1, pfac_pkg::IDX_AUTO, c);
    @(posedge pclk); ev[eb] <= 1;
    wmode(t); chk(aa, 1);
    repeat (3) @(negedge pclk); chk(irq, 1);
    @(posedge pclk); ev[xb] <= xv;
    wmode(2'b00); chk(aa, 0);
    apb(0, pfac_pkg::IDX_STATUS, 0); chk(r, 32'h0000_0003);
    repeat (2) @(negedge pclk); chk(irq, 0);
    @(posedge pclk); ev <= '0;
    repeat (3) @(posedge pclk);
  endtask
  task t_auto;
    apb(1, pfac_pkg::IDX_MASK, 8'h01); apb(0, pfac_pkg::IDX_STATUS, 0);
    seq(8'h25, 0, 0, 0, 2'b01);
    seq(8'h9e, 3, 6, 1, 2'b10);
    seq(8'hcd, 5, 2, 1, 2'b01);
    seq(8'h56, 1, 4, 1, 2'b10);
  endtask
  initial begin
    err_total = 0; checks_done = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; ev = '0; rav = 0; rlv = 0; rab = '0; rlb = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    t_reset; t_filter; t_len; t_auto;
    stop_test;
  end
  initial begin
    repeat (3000) @(posedge pclk);
    err_total++;
    stop_test;
  end
endmodule // pfac_top_tb
